// ### logic/msp_pkg.sv
// constants and types shared by the metering serial slave port
package msp_pkg;

    // ========================================================
    // timing
    localparam int CLK_MHZ      = 20;
    localparam int TIMEOUT_NS   = 9150000;
    localparam int TIMEOUT_CYC  = TIMEOUT_NS * CLK_MHZ / 1000;
    localparam int TIMER_W      = 18;

    // ========================================================
    // widths and bit positions
    localparam int BYTE_W       = 8;
    localparam int DATA_W       = 32;
    localparam int ADDR_W       = 7;
    localparam int SIZE_W       = 2;
    localparam int DIR_BIT      = 7;
    localparam int SYNC_W       = 2;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    // ========================================================
    // command and special codes
    localparam logic [7:0] CMD_SPECIAL = 8'hea;
    localparam logic [7:0] SP_OPEN     = 8'he5;
    localparam logic [7:0] SP_CLOSE    = 8'hdc;
    localparam logic [7:0] SP_CHAN_A   = 8'h5a;
    localparam logic [7:0] SP_CHAN_B   = 8'ha5;
    localparam logic [7:0] SP_RESET    = 8'h96;
    localparam logic [7:0] TX_IDLE     = 8'h00;

    // ========================================================
    // port sequencing states
    typedef enum logic [2:0] {
        ST_CMD,
        ST_SPECIAL,
        ST_RD_LOOK,
        ST_RD_SEND,
        ST_WR_LOOK,
        ST_WR_DATA
    } msp_state_t;

endpackage

// ### logic/msp_port.sv
// serial slave port: link shifter and command sequencer
// Function
// - port works only while port_mode_select is high.
// - output bits change on rising edge, input bits sampled on falling.
// - reads and writes follow back to back under one select.
// - more than 9.15 ms between rising edges resets the port.
// - every transaction opens with a command byte, direction and address.
// - command bit 7 set means write, clear means read.
// - command 0xea is special; following byte gives its meaning.
// - 0xe5 opens protected writes, 0xdc closes them.
// - 0x5a selects current channel A, 0xa5 channel B.
// - special reset code requests a full chip reset.
// - bytes travel most significant bit first.
// - multi-byte registers travel high byte first.
// - read command sends the addressed register out bitwise.
`timescale 1ns/1ps
module msp_port #(
    parameter int TIMEOUT_CYCLES = msp_pkg::TIMEOUT_CYC
) (
    // system clock and reset
    input  wire logic                         clock,
    input  wire logic                         rst,
    // serial link
    input  wire logic                         serial_clock,
    input  wire logic                         chip_select_n,
    input  wire logic                         serial_in,
    output logic                              serial_out,
    output logic                              serial_out_en,
    // mode strap
    input  wire logic                         port_mode_select,
    // register map access
    output logic [msp_pkg::ADDR_W-1:0]        reg_addr,
    input  wire logic [msp_pkg::SIZE_W-1:0]   reg_size,
    input  wire logic                         reg_protected,
    input  wire logic [msp_pkg::DATA_W-1:0]   rd_data,
    output logic                              rd_strobe,
    output logic                              wr_strobe,
    output logic [msp_pkg::DATA_W-1:0]        wr_data,
    // control state
    output logic                              write_open,
    output logic                              channel_b_sel,
    output logic                              chip_reset,
    output logic                              port_timeout
);
    import msp_pkg::*;

    // ========================================================
    // declarations
    msp_state_t            state_reg;
    logic [2:0]            rx_cnt_reg;
    logic [BYTE_W-1:0]     rx_shift_reg;
    logic [BYTE_W-1:0]     rx_hold_reg;
    logic                  rx_tog_reg;
    logic                  rise_tog_reg;
    logic [2:0]            tx_cnt_reg;
    logic [BYTE_W-1:0]     tx_shift_reg;
    logic [BYTE_W-1:0]     tx_hold_reg;
    logic                  link_clr;
    logic                  mode_link;
    logic [SYNC_W-1:0]     pins_s;
    logic                  cs_s;
    logic                  mode_s;
    logic                  rx_evt;
    logic                  rise_evt;
    logic                  abort;
    logic                  flush_reg;
    logic [TIMER_W-1:0]    timer_reg;
    logic [SIZE_W-1:0]     cnt_reg;
    logic [DATA_W-1:0]     rd_buf_reg;
    logic [DATA_W-1:0]     wr_acc_reg;
    logic [DATA_W-1:0]     wr_word;
    logic                  sp_evt;

    function automatic logic [BYTE_W-1:0] byte_sel(
        input logic [DATA_W-1:0] word,
        input logic [SIZE_W-1:0] idx
    );
        byte_sel = word[{idx, 3'h0} +: BYTE_W];
    endfunction

    // ========================================================
    // link domain
    assign link_clr = chip_select_n | flush_reg;

    msp_sync #(.WIDTH(1)) u_mode_link (
        .clock     (serial_clock),
        .clear     (rst),
        .level_in  (port_mode_select),
        .level_out (mode_link)
    );

    always_ff @(negedge serial_clock or posedge link_clr) begin
        if (link_clr) begin
            rx_cnt_reg   <= BIT_FIRST;
            rx_shift_reg <= '0;
        end else begin
            rx_cnt_reg   <= rx_cnt_reg + 3'h1;
            rx_shift_reg <= {rx_shift_reg[BYTE_W-2:0], serial_in};
        end
    end

    always_ff @(negedge serial_clock or posedge rst) begin
        if (rst) begin
            rx_tog_reg  <= 1'b0;
            rx_hold_reg <= '0;
        end else if (rx_cnt_reg == BIT_LAST) begin
            rx_hold_reg <= {rx_shift_reg[BYTE_W-2:0], serial_in};
            rx_tog_reg  <= ~rx_tog_reg;
        end
    end

    always_ff @(posedge serial_clock or posedge rst) begin
        if (rst) begin
            rise_tog_reg <= 1'b0;
        end else begin
            rise_tog_reg <= ~rise_tog_reg;
        end
    end

    always_ff @(posedge serial_clock or posedge link_clr) begin
        if (link_clr) begin
            tx_cnt_reg    <= BIT_FIRST;
            tx_shift_reg  <= '0;
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end else begin
            tx_cnt_reg    <= tx_cnt_reg + 3'h1;
            serial_out_en <= mode_link;
            if (tx_cnt_reg == BIT_FIRST) begin
                serial_out   <= tx_hold_reg[BYTE_W-1];
                tx_shift_reg <= {tx_hold_reg[BYTE_W-2:0], 1'b0};
            end else begin
                serial_out   <= tx_shift_reg[BYTE_W-1];
                tx_shift_reg <= {tx_shift_reg[BYTE_W-2:0], 1'b0};
            end
        end
    end

    // ========================================================
    // crossings into the system domain
    msp_sync #(.WIDTH(SYNC_W)) u_pins (
        .clock     (clock),
        .clear     (rst),
        .level_in  ({chip_select_n, port_mode_select}),
        .level_out (pins_s)
    );
    assign cs_s   = pins_s[1];
    assign mode_s = pins_s[0];

    msp_toggle_rx u_rx_evt (
        .clock     (clock),
        .rst       (rst),
        .toggle_in (rx_tog_reg),
        .pulse_out (rx_evt)
    );

    msp_toggle_rx u_rise_evt (
        .clock     (clock),
        .rst       (rst),
        .toggle_in (rise_tog_reg),
        .pulse_out (rise_evt)
    );

    assign abort   = cs_s | ~mode_s | flush_reg;
    assign sp_evt  = (state_reg == ST_SPECIAL) && rx_evt;
    assign wr_word = {wr_acc_reg[DATA_W-BYTE_W-1:0], rx_hold_reg};

    // ========================================================
    // inactivity timeout
    always_ff @(posedge clock) begin
        if (rst || cs_s || !mode_s || rise_evt) begin
            timer_reg    <= '0;
            flush_reg    <= 1'b0;
            port_timeout <= 1'b0;
        end else if (timer_reg == TIMER_W'(TIMEOUT_CYCLES - 1)) begin
            timer_reg    <= '0;
            flush_reg    <= 1'b1;
            port_timeout <= 1'b1;
        end else begin
            timer_reg    <= timer_reg + TIMER_W'(1);
            flush_reg    <= 1'b0;
            port_timeout <= 1'b0;
        end
    end

    // ========================================================
    // command sequencer
    always_ff @(posedge clock) begin
        if (rst || abort || chip_reset) begin
            state_reg <= ST_CMD;
        end else begin
            unique case (state_reg)
                ST_CMD: if (rx_evt) begin
                    if (rx_hold_reg == CMD_SPECIAL)
                        state_reg <= ST_SPECIAL;
                    else if (rx_hold_reg[DIR_BIT])
                        state_reg <= ST_WR_LOOK;
                    else
                        state_reg <= ST_RD_LOOK;
                end
                ST_SPECIAL: if (rx_evt) begin
                    state_reg <= ST_CMD;
                end
                ST_RD_LOOK: state_reg <= ST_RD_SEND;
                ST_RD_SEND: if (rx_evt && cnt_reg == '0) begin
                    state_reg <= ST_CMD;
                end
                ST_WR_LOOK: state_reg <= ST_WR_DATA;
                ST_WR_DATA: if (rx_evt && cnt_reg == '0) begin
                    state_reg <= ST_CMD;
                end
                default: state_reg <= ST_CMD;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_addr <= '0;
        end else if (state_reg == ST_CMD && rx_evt) begin
            reg_addr <= rx_hold_reg[ADDR_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (state_reg == ST_RD_LOOK || state_reg == ST_WR_LOOK) begin
            cnt_reg <= reg_size;
        end else if (rx_evt && cnt_reg != '0 &&
                     (state_reg == ST_RD_SEND || state_reg == ST_WR_DATA)) begin
            cnt_reg <= cnt_reg - SIZE_W'(1);
        end
    end

    // ========================================================
    // read path
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_buf_reg <= '0;
            rd_strobe  <= 1'b0;
        end else begin
            rd_strobe <= (state_reg == ST_RD_LOOK);
            if (state_reg == ST_RD_LOOK) begin
                rd_buf_reg <= rd_data;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst || abort) begin
            tx_hold_reg <= TX_IDLE;
        end else if (state_reg == ST_RD_LOOK) begin
            tx_hold_reg <= byte_sel(rd_data, reg_size);
        end else if (state_reg == ST_RD_SEND && rx_evt) begin
            if (cnt_reg == '0)
                tx_hold_reg <= TX_IDLE;
            else
                tx_hold_reg <= byte_sel(rd_buf_reg, cnt_reg - SIZE_W'(1));
        end
    end

    // ========================================================
    // write path
    always_ff @(posedge clock) begin
        if (rst || state_reg == ST_WR_LOOK) begin
            wr_acc_reg <= '0;
        end else if (state_reg == ST_WR_DATA && rx_evt) begin
            wr_acc_reg <= wr_word;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_strobe <= 1'b0;
            wr_data   <= '0;
        end else if (state_reg == ST_WR_DATA && rx_evt && cnt_reg == '0 &&
                     !abort) begin
            wr_strobe <= !reg_protected || write_open;
            wr_data   <= wr_word;
        end else begin
            wr_strobe <= 1'b0;
        end
    end

    // ========================================================
    // special commands
    always_ff @(posedge clock) begin
        if (rst || chip_reset) begin
            write_open <= 1'b0;
        end else if (sp_evt && rx_hold_reg == SP_OPEN) begin
            write_open <= 1'b1;
        end else if (sp_evt && rx_hold_reg == SP_CLOSE) begin
            write_open <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || chip_reset) begin
            channel_b_sel <= 1'b0;
        end else if (sp_evt && rx_hold_reg == SP_CHAN_A) begin
            channel_b_sel <= 1'b0;
        end else if (sp_evt && rx_hold_reg == SP_CHAN_B) begin
            channel_b_sel <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            chip_reset <= 1'b0;
        end else begin
            chip_reset <= sp_evt && rx_hold_reg == SP_RESET && !abort;
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_special_open;
        sp_evt && rx_hold_reg == SP_OPEN && !chip_reset;
    endsequence

    sequence s_last_wr_byte;
        state_reg == ST_WR_DATA && rx_evt && cnt_reg == '0 && !abort;
    endsequence

    a_open_write: assert property (s_special_open |=> write_open)
        else $error("open code did not open writes");
    a_close_write: assert property (
        sp_evt && rx_hold_reg == SP_CLOSE |=> !write_open)
        else $error("close code did not close writes");
    a_protect_block: assert property (
        s_last_wr_byte ##0 (reg_protected && !write_open) |=> !wr_strobe)
        else $error("protected write went through");
    a_write_issue: assert property (
        s_last_wr_byte ##0 !reg_protected |=> wr_strobe &&
        wr_data == $past(wr_word))
        else $error("write not issued with data");
    a_chan_b_sel: assert property (
        sp_evt && rx_hold_reg == SP_CHAN_B && !chip_reset |=> channel_b_sel)
        else $error("channel b not selected");
    a_reset_pulse: assert property (
        sp_evt && rx_hold_reg == SP_RESET && !abort |=> chip_reset
        ##1 (!chip_reset && !write_open && !channel_b_sel))
        else $error("reset command mishandled");
    a_read_first: assert property (
        state_reg == ST_RD_LOOK && !abort |=> state_reg == ST_RD_SEND &&
        rd_strobe && tx_hold_reg == byte_sel($past(rd_data), reg_size))
        else $error("read first byte wrong");
    a_select_drop: assert property (cs_s |=> state_reg == ST_CMD &&
        tx_hold_reg == TX_IDLE)
        else $error("select high did not drop command");
    a_mode_gate: assert property (!mode_s |=> state_reg == ST_CMD)
        else $error("port active with mode low");
    a_timeout_flush: assert property (
        !cs_s && mode_s && !rise_evt &&
        timer_reg == TIMER_W'(TIMEOUT_CYCLES - 1) |=> flush_reg
        ##1 (!flush_reg && state_reg == ST_CMD))
        else $error("timeout did not flush port");

endmodule

// ### logic/msp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module msp_sync #(
    parameter int WIDTH = 1
) (
    // clock and clear
    input  wire logic             clock,
    input  wire logic             clear,
    // level in and out
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);
    import msp_pkg::*;

    logic [WIDTH-1:0] stage_reg;

    // ========================================================
    // two stages, first read only by second
    always_ff @(posedge clock or posedge clear) begin
        if (clear) begin
            stage_reg <= '0;
            level_out <= '0;
        end else begin
            stage_reg <= level_in;
            level_out <= stage_reg;
        end
    end

endmodule

// ### logic/msp_toggle_rx.sv
// toggle to pulse crossing
`timescale 1ns/1ps
module msp_toggle_rx (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // toggle in, pulse out
    input  wire logic toggle_in,
    output logic      pulse_out
);
    import msp_pkg::*;

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ========================================================
    // sync then edge detect on the second stage
    always_ff @(posedge clock) begin
        if (rst) begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            s1_reg    <= toggle_in;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            pulse_out <= s2_reg ^ s3_reg;
        end
    end

endmodule

// ### test/msp_host_model.sv
// behavioural serial host facing the slave port
`timescale 1ns/1ps
module msp_host_model #(
    parameter int HALF_NS = 32,
    parameter int GAP_NS  = 500
) (
    // serial link
    output logic      serial_clock,
    output logic      chip_select_n,
    output logic      serial_in,
    input  wire logic serial_out
);
    // select rises after time zero so the link clear sees a clean edge
    initial begin
        serial_clock  = 1'b0;
        serial_in     = 1'b0;
        #1;
        chip_select_n = 1'b1;
    end

    // ========================================================
    // frame control
    task automatic select_on();
        chip_select_n = 1'b0;
        #(GAP_NS);
    endtask

    task automatic select_off();
        #(HALF_NS);
        chip_select_n = 1'b1;
        serial_in     = ~serial_in;
        #(GAP_NS);
    endtask

    // ========================================================
    // one byte, msb first; fewer than 8 bits cuts it short
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            serial_clock = 1'b1;
            serial_in    = tx[i];
            #(HALF_NS);
            serial_clock = 1'b0;
            rx[i]        = serial_out;
            #(HALF_NS);
        end
        #(GAP_NS);
    endtask
endmodule

// ### test/msp_port_tb_top.sv
// self-checking bench for the serial slave port
`timescale 1ns/1ps
module msp_port_tb_top;
    import msp_pkg::*;

    typedef struct packed {
        logic        wr;
        logic [6:0]  addr;
        logic [31:0] data;
    } msp_row_t;

    // ========================================================
    // signals
    logic              clock;
    logic              rst;
    logic              serial_clock;
    logic              chip_select_n;
    logic              serial_in;
    logic              serial_out;
    logic              serial_out_en;
    logic              port_mode_select;
    logic [ADDR_W-1:0] reg_addr;
    logic [SIZE_W-1:0] reg_size;
    logic              reg_protected;
    logic [DATA_W-1:0] rd_data;
    logic              rd_strobe;
    logic              wr_strobe;
    logic [DATA_W-1:0] wr_data;
    logic              write_open;
    logic              channel_b_sel;
    logic              chip_reset;
    logic              port_timeout;
    logic [31:0]       wr_seen;
    logic [6:0]        wr_at;
    logic [31:0]       rxw;
    logic [7:0]        rx;
    int                n_errors;
    int                check_count;
    int                cycles;
    int                wr_cnt;
    int                rd_cnt;
    int                rs_cnt;
    int                tmo_cnt;
    int                exp_wr;

    localparam msp_row_t ROWS [8] = '{
        {1'b0, 7'h00, 32'h0}, {1'b0, 7'h01, 32'h0},
        {1'b0, 7'h02, 32'h0}, {1'b0, 7'h03, 32'h0},
        {1'b1, 7'h01, 32'h00001234}, {1'b1, 7'h03, 32'hdeadbeef},
        {1'b1, 7'h02, 32'h00a5c381}, {1'b0, 7'h3b, 32'h0}};

    // ========================================================
    // register map stand-in
    function automatic logic [31:0] rd_word(input logic [6:0] a);
        return {1'b1, a, ~a, 1'b0, 8'h3c, a, 1'b1};
    endfunction

    function automatic logic [31:0] size_mask(input logic [1:0] s);
        return (s == 2'h3) ? 32'hffffffff
                           : ((32'h1 << (8 * (int'(s) + 1))) - 32'h1);
    endfunction

    assign reg_size      = reg_addr[1:0];
    assign reg_protected = reg_addr[6];
    assign rd_data       = rd_word(reg_addr);

    // ========================================================
    // instances
    msp_port #(.TIMEOUT_CYCLES(200)) i_msp_port (
        .clock(clock), .rst(rst), .serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_en(serial_out_en),
        .port_mode_select(port_mode_select), .reg_addr(reg_addr),
        .reg_size(reg_size), .reg_protected(reg_protected),
        .rd_data(rd_data), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .write_open(write_open),
        .channel_b_sel(channel_b_sel), .chip_reset(chip_reset),
        .port_timeout(port_timeout));

    msp_host_model i_msp_host_model (
        .serial_clock(serial_clock), .chip_select_n(chip_select_n),
        .serial_in(serial_in), .serial_out(serial_out));

    // ========================================================
    // clock, event counters and hang limit
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (wr_strobe === 1'b1) begin
            wr_cnt++;
            wr_seen = wr_data;
            wr_at   = reg_addr;
        end
        if (rd_strobe === 1'b1) rd_cnt++;
        if (chip_reset === 1'b1) rs_cnt++;
        if (port_timeout === 1'b1) tmo_cnt++;
        if (cycles == 8000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic [7:0] b);
        i_msp_host_model.xfer(b, 8, rx);
    endtask

    task automatic do_write(input logic [6:0] a, input logic [31:0] d);
        i_msp_host_model.select_on();
        send({1'b1, a});
        for (int k = int'(a[1:0]); k >= 0; k--) send(d[8*k +: 8]);
        i_msp_host_model.select_off();
    endtask

    task automatic do_special(input logic [7:0] code);
        i_msp_host_model.select_on();
        send(CMD_SPECIAL);
        send(code);
        i_msp_host_model.select_off();
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ========================================================
    // main sequence
    initial begin
        rst              = 1'b0;
        port_mode_select = 1'b1;
        @(posedge clock);
        rst <= 1'b1;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        check({25'h0, write_open, channel_b_sel, chip_reset, port_timeout,
               wr_strobe, rd_strobe, serial_out_en}, 32'h0);
        // all rows back to back under one select
        i_msp_host_model.select_on();
        foreach (ROWS[r]) begin
            if (ROWS[r].wr) begin
                send({1'b1, ROWS[r].addr});
                for (int k = int'(ROWS[r].addr[1:0]); k >= 0; k--)
                    send(ROWS[r].data[8*k +: 8]);
                exp_wr++;
                check(wr_cnt, exp_wr);
                check(wr_seen & size_mask(ROWS[r].addr[1:0]),
                      ROWS[r].data);
                check({25'h0, wr_at}, {25'h0, ROWS[r].addr});
            end else begin
                rxw = 32'h0;
                send({1'b0, ROWS[r].addr});
                for (int k = int'(ROWS[r].addr[1:0]); k >= 0; k--) begin
                    i_msp_host_model.xfer(8'h00, 8, rx);
                    rxw = {rxw[23:0], rx};
                end
                check(rxw, rd_word(ROWS[r].addr)
                      & size_mask(ROWS[r].addr[1:0]));
                check({31'h0, serial_out_en}, 32'h1);
            end
        end
        i_msp_host_model.select_off();
        check(rd_cnt, 32'h5);
        // partial command dropped when select rises
        i_msp_host_model.select_on();
        i_msp_host_model.xfer(8'h81, 4, rx);
        i_msp_host_model.select_off();
        check({31'h0, serial_out_en}, 32'h0);
        do_write(7'h01, 32'h00005678);
        exp_wr++;
        check(wr_cnt, exp_wr);
        check(wr_seen & 32'hffff, 32'h5678);
        // port ignores traffic with the mode strap low
        @(posedge clock);
        port_mode_select <= 1'b0;
        repeat (4) @(posedge clock);
        do_write(7'h01, 32'h00009999);
        check(wr_cnt, exp_wr);
        @(posedge clock);
        port_mode_select <= 1'b1;
        repeat (4) @(posedge clock);
        // protection and special codes
        do_write(7'h41, 32'h0000beef);
        check(wr_cnt, exp_wr);
        do_special(SP_OPEN);
        check({31'h0, write_open}, 32'h1);
        do_write(7'h41, 32'h0000beef);
        exp_wr++;
        check(wr_cnt, exp_wr);
        do_special(SP_CLOSE);
        check({31'h0, write_open}, 32'h0);
        do_write(7'h42, 32'h00123456);
        check(wr_cnt, exp_wr);
        do_special(SP_CHAN_B);
        check({31'h0, channel_b_sel}, 32'h1);
        do_special(8'h11);
        check({31'h0, channel_b_sel}, 32'h1);
        do_special(SP_CHAN_A);
        check({31'h0, channel_b_sel}, 32'h0);
        do_special(SP_CHAN_B);
        do_special(SP_OPEN);
        do_special(SP_RESET);
        check(rs_cnt, 32'h1);
        check({30'h0, write_open, channel_b_sel}, 32'h0);
        check(wr_cnt, exp_wr);
        // inactivity timeout, just under and past the limit
        i_msp_host_model.select_on();
        i_msp_host_model.xfer(8'h82, 3, rx);
        repeat (150) @(posedge clock);
        check(tmo_cnt, 32'h0);
        repeat (100) @(posedge clock);
        check(tmo_cnt, 32'h1);
        i_msp_host_model.select_off();
        do_write(7'h02, 32'h00abcdef);
        exp_wr++;
        check(wr_cnt, exp_wr);
        check(wr_seen & 32'hffffff, 32'h00abcdef);
        give_verdict();
    end
endmodule
